// ===== core/grs_ctrl.v
// Reset sequencer, abort and polling status of an IEEE-488 controller companion.
// Assumes all inputs synchronous to core_clk_i; bus outputs are active low.
`timescale 1ns/1ns
`include "grs_regs.vh"

module grs_ctrl (
    input  wire       core_clk_i,
    input  wire       reset_i,
    input  wire       soft_reset_i,
    input  wire       is_sys_ctrl_i,
    input  wire       ifc_received_i,
    input  wire       out_buf_full_flag_i,
    input  wire       in_buf_full_flag_i,
    input  wire       task_done_set_i,
    input  wire       srq_event_i,
    input  wire       err_event_i,
    input  wire       count_event_i,
    input  wire       count_enable_set_i,
    input  wire       mask_wr_i,
    input  wire [7:0] mask_data_i,
    input  wire       ack_wr_i,
    input  wire [7:0] ack_data_i,
    output reg  [7:0] int_status_o,
    output reg  [7:0] int_mask_o,
    output reg  [7:0] err_flag_o,
    output reg  [7:0] err_mask_o,
    output reg  [7:0] timeout_o,
    output reg  [7:0] event_count_o,
    output reg        count_enabled_o,
    output reg        srq_n_o,
    output reg        attention_out_n_o,
    output reg        ifc_n_o,
    output reg        ren_n_o,
    output reg        eoi_n_o,
    output reg        dav_n_o,
    output reg        in_charge_out_n_o,
    output reg        system_ctrl_out_n_o,
    output reg        task_done_irq_o,
    output reg        special_irq_o,
    output reg        out_buf_full_irq_o,
    output reg        in_buf_not_full_irq_o,
    output reg        clear_latch_out_o,
    output reg        in_cacs_o,
    output reg        busy_o
);

    // Sequencer states
    localparam [2:0] ST_BUS_HIGH = 3'h0;
    localparam [2:0] ST_IRQ_LOW  = 3'h1;
    localparam [2:0] ST_CLR_REGS = 3'h2;
    localparam [2:0] ST_DECIDE   = 3'h3;
    localparam [2:0] ST_ABORT    = 3'h4;
    localparam [2:0] ST_IDLE     = 3'h5;

    // Last count of the clear pulse, cut to the counter width
    localparam integer IFC_CYCLES = `GRS_IFC_CYCLES;
    localparam [12:0]  IFC_LAST   = IFC_CYCLES[12:0] - 13'h0001;

    // Sequencer state, clear pulse counter and next polled status
    reg [2:0]  state_reg;
    reg [12:0] ifc_cnt_reg;
    reg [7:0]  status_next;

    // Any reset source restarts the same sequence
    wire any_reset = reset_i | soft_reset_i;

    // Interrupt line: pending condition passed only when enabled
    function irq_gate;
        input pending;
        input enable;
        begin
            irq_gate = pending & enable;
        end
    endfunction

    // Sticky special events, set wins over acknowledge
    always @* begin
        status_next = int_status_o & ~(ack_wr_i ? ack_data_i : 8'h00);
        // Buffer flags follow their pins directly
        status_next[`GRS_ST_OBF] = out_buf_full_flag_i;
        status_next[`GRS_ST_IBF] = in_buf_full_flag_i;
        status_next[`GRS_ST_SYC] = is_sys_ctrl_i;
        if (task_done_set_i)
            status_next[`GRS_ST_TASK] = 1'b1;
        if (ifc_received_i)
            status_next[`GRS_ST_IFC] = 1'b1;
        // Terminal count: the 256th event takes the counter from 01 to 00
        if (count_event_i && count_enabled_o && event_count_o == 8'h01)
            status_next[`GRS_ST_EV] = 1'b1;
        if (err_event_i)
            status_next[`GRS_ST_ERR] = 1'b1;
        if (srq_event_i)
            status_next[`GRS_ST_SRQ] = 1'b1;
    end

    // Reset sequence, abort pulse and register file
    always @(posedge core_clk_i) begin
        if (any_reset) begin
            // Bus lines released, interrupt lines parked high
            state_reg           <= ST_BUS_HIGH;
            ifc_cnt_reg         <= 13'h0000;
            busy_o              <= 1'b1;
            in_cacs_o           <= 1'b0;
            srq_n_o             <= 1'b1;
            attention_out_n_o   <= 1'b1;
            ifc_n_o             <= 1'b1;
            ren_n_o             <= 1'b1;
            eoi_n_o             <= 1'b1;
            dav_n_o             <= 1'b1;
            in_charge_out_n_o   <= 1'b1;
            system_ctrl_out_n_o <= 1'b1;
            task_done_irq_o     <= 1'b1;
            special_irq_o       <= 1'b1;
            out_buf_full_irq_o  <= 1'b1;
            in_buf_not_full_irq_o <= 1'b1;
            clear_latch_out_o   <= 1'b1;
            int_status_o        <= `GRS_RST_STATUS;
            int_mask_o          <= `GRS_RST_MASK;
            err_flag_o          <= `GRS_RST_ERR;
            err_mask_o          <= `GRS_RST_ERRMASK;
            timeout_o           <= `GRS_RST_TIMEOUT;
            event_count_o       <= `GRS_RST_EVCNT;
            count_enabled_o     <= 1'b0;
        end else begin
            case (state_reg)
                ST_BUS_HIGH: begin
                    // Bus lines stay released for this cycle
                    state_reg <= ST_IRQ_LOW;
                end
                ST_IRQ_LOW: begin
                    // Interrupt lines and clear latch fall together
                    task_done_irq_o       <= 1'b0;
                    special_irq_o         <= 1'b0;
                    out_buf_full_irq_o    <= 1'b0;
                    in_buf_not_full_irq_o <= 1'b0;
                    clear_latch_out_o     <= 1'b0;
                    state_reg             <= ST_CLR_REGS;
                end
                ST_CLR_REGS: begin
                    // Registers already hold reset values; counter loaded with 00 and disabled
                    int_status_o    <= `GRS_RST_STATUS;
                    int_mask_o      <= `GRS_RST_MASK;
                    err_flag_o      <= `GRS_RST_ERR;
                    err_mask_o      <= `GRS_RST_ERRMASK;
                    timeout_o       <= `GRS_RST_TIMEOUT;
                    event_count_o   <= `GRS_RST_EVCNT;
                    count_enabled_o <= 1'b0;
                    state_reg       <= ST_DECIDE;
                end
                ST_DECIDE: begin
                    // System controller seizes the bus by an abort
                    system_ctrl_out_n_o <= ~is_sys_ctrl_i;
                    if (is_sys_ctrl_i) begin
                        ifc_n_o     <= 1'b0;
                        ifc_cnt_reg <= 13'h0000;
                        state_reg   <= ST_ABORT;
                    end else begin
                        busy_o    <= 1'b0;
                        state_reg <= ST_IDLE;
                    end
                end
                ST_ABORT: begin
                    // Hold clear for the full minimum pulse
                    if (ifc_cnt_reg == IFC_LAST) begin
                        ifc_n_o           <= 1'b1;
                        attention_out_n_o <= 1'b0;
                        in_charge_out_n_o <= 1'b0;
                        in_cacs_o         <= 1'b1;
                        busy_o            <= 1'b0;
                        state_reg         <= ST_IDLE;
                    end else begin
                        ifc_cnt_reg <= ifc_cnt_reg + 13'h0001;
                    end
                end
                ST_IDLE: begin
                    // Polled status and mask writes
                    int_status_o <= status_next;
                    if (mask_wr_i)
                        int_mask_o <= mask_data_i;
                    // Counter runs only once enabled
                    if (count_enable_set_i)
                        count_enabled_o <= 1'b1;
                    if (count_event_i && count_enabled_o)
                        event_count_o <= event_count_o - 8'h01;
                    // Interrupt outputs gated by the mask
                    task_done_irq_o <= irq_gate(status_next[`GRS_ST_TASK],
                                                int_mask_o[`GRS_MK_TASK]);
                    special_irq_o <= irq_gate(|status_next[`GRS_ST_SRQ:`GRS_ST_IFC],
                                              int_mask_o[`GRS_MK_SPEC]);
                    out_buf_full_irq_o <= irq_gate(out_buf_full_flag_i,
                                                   int_mask_o[`GRS_MK_OBF]);
                    in_buf_not_full_irq_o <= irq_gate(~in_buf_full_flag_i,
                                                      int_mask_o[`GRS_MK_IBF]);
                    clear_latch_out_o <= ifc_received_i;
                    // Received clear aborts control: release attention and EOI
                    if (ifc_received_i && !is_sys_ctrl_i) begin
                        attention_out_n_o <= 1'b1;
                        eoi_n_o           <= 1'b1;
                        in_charge_out_n_o <= 1'b1;
                        dav_n_o           <= 1'b1;
                        in_cacs_o         <= 1'b0;
                    end
                end
                default: begin
                    state_reg <= ST_BUS_HIGH;
                end
            endcase
        end
    end

endmodule // grs_ctrl

// ===== core/grs_regs.vh
// Constants for the controller reset, abort and polling-status block.
// Assumes a 50 MHz core clock; included by the block's single design file.
`ifndef GRS_REGS_VH
`define GRS_REGS_VH

// Clock period in ns and clear pulse minimum in us
`define GRS_CLK_NS          20
`define GRS_IFC_MIN_US      100
// Least clear pulse in cycles, rounded up
`define GRS_IFC_CYCLES      ((`GRS_IFC_MIN_US * 1000 + `GRS_CLK_NS - 1) / `GRS_CLK_NS)

// Interrupt status bit positions
`define GRS_ST_OBF          0
`define GRS_ST_IBF          1
`define GRS_ST_TASK         2
`define GRS_ST_IFC          3
`define GRS_ST_EV           4
`define GRS_ST_ERR          5
`define GRS_ST_SRQ          6
`define GRS_ST_SYC          7

// Interrupt mask bit positions
`define GRS_MK_TASK         0
`define GRS_MK_SPEC         1
`define GRS_MK_OBF          2
`define GRS_MK_IBF          3

// Reset values
`define GRS_RST_STATUS      8'h00
`define GRS_RST_MASK        8'h00
`define GRS_RST_ERR         8'h00
`define GRS_RST_ERRMASK     8'h00
`define GRS_RST_TIMEOUT     8'h00
`define GRS_RST_EVCNT       8'h00

`endif

// ===== verification/grs_ctrl_chk.sv
// Checker for the reset sequencer, abort and polling status.
// Assumes one clock; bound to every grs_ctrl by the bind below.
`timescale 1ns/1ns
module grs_ctrl_chk (
    input wire       core_clk_i,
    input wire       reset_i,
    input wire       soft_reset_i,
    input wire       is_sys_ctrl_i,
    input wire       ifc_received_i,
    input wire       out_buf_full_flag_i,
    input wire       busy_o,
    input wire       in_cacs_o,
    input wire       srq_n_o,
    input wire       attention_out_n_o,
    input wire       ifc_n_o,
    input wire       ren_n_o,
    input wire       eoi_n_o,
    input wire       dav_n_o,
    input wire       in_charge_out_n_o,
    input wire       task_done_irq_o,
    input wire       special_irq_o,
    input wire       out_buf_full_irq_o,
    input wire       in_buf_not_full_irq_o,
    input wire       clear_latch_out_o,
    input wire [7:0] int_mask_o,
    input wire [7:0] err_flag_o,
    input wire [7:0] err_mask_o,
    input wire [7:0] timeout_o,
    input wire [7:0] event_count_o,
    input wire [7:0] int_status_o
);
    reg  [15:0] low_cnt_reg;
    wire        irqs = task_done_irq_o | special_irq_o | out_buf_full_irq_o
                       | in_buf_not_full_irq_o;
    // Cycles with the clear line held low
    always @(posedge core_clk_i) begin
        low_cnt_reg <= (ifc_n_o | reset_i | soft_reset_i) ? 16'h0000 : low_cnt_reg + 16'h0001;
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (reset_i | soft_reset_i);
    sequence rel_s; $fell(reset_i | soft_reset_i); endsequence
    sequence hi_s; srq_n_o & attention_out_n_o & ifc_n_o & ren_n_o & eoi_n_o & dav_n_o
        & in_charge_out_n_o; endsequence
    bus_high_a: assert property (rel_s |-> hi_s ##1 hi_s)
        else $error("bus lines not high after reset");
    irq_low_a: assert property (rel_s |-> ##2 !(irqs | clear_latch_out_o))
        else $error("interrupt outputs not low");
    regs_clear_a: assert property (rel_s |-> ##3 (int_mask_o | err_flag_o | err_mask_o
        | timeout_o | event_count_o) == 8'h00) else $error("registers not cleared");
    clear_len_a: assert property ($rose(ifc_n_o) |-> low_cnt_reg == 16'h1388)
        else $error("clear pulse length wrong");
    take_ctl_a: assert property ($rose(ifc_n_o) |-> !attention_out_n_o
        && !in_charge_out_n_o && in_cacs_o && !busy_o) else $error("control not taken");
    stay_idle_a: assert property (rel_s ##0 !is_sys_ctrl_i |-> ##4 !busy_o
        && !in_cacs_o && ifc_n_o) else $error("non controller not idle");
    mask_all_a: assert property (!busy_o && int_mask_o == 8'h00 |=> !irqs)
        else $error("masked interrupt raised");
    obf_poll_a: assert property (!busy_o |=> int_status_o[0] == $past(out_buf_full_flag_i))
        else $error("buffer flag not in status");
    clear_drop_a: assert property (ifc_received_i && !busy_o && !is_sys_ctrl_i |=>
        attention_out_n_o && eoi_n_o && !in_cacs_o) else $error("clear not obeyed");
endmodule // grs_ctrl_chk
bind grs_ctrl grs_ctrl_chk i_grs_ctrl_chk (.*);

// ===== verification/grs_gate_model.sv
// Bus-side gating that releases the controller lines on clear.
// Assumes active-low bus lines and a high-active received clear.
`timescale 1ns/1ns
module grs_gate_model (
    input  wire ifc_received_i,
    input  wire in_charge_out_n_i,
    input  wire attention_out_n_i,
    output wire bus_in_charge_n_o,
    output wire bus_attention_n_o
);
    // Clear forces both lines released
    assign bus_in_charge_n_o = in_charge_out_n_i | ifc_received_i;
    assign bus_attention_n_o = attention_out_n_i | ifc_received_i;
endmodule // grs_gate_model

// ===== verification/grs_ctrl_tb.sv
// Self-checking bench for grs_ctrl with the bus gating model.
// Assumes 50 MHz; inputs change 1 ns after each rising edge.
`timescale 1ns/1ns
module grs_ctrl_tb;
    reg        clk = 1'b0, rst = 1'b1, srst = 1'b0, sysc = 1'b0, ifc = 1'b0, out_buf_full_flag = 1'b0;
    reg        td = 1'b0, ev = 1'b0, ce = 1'b0, mwr = 1'b0, awr = 1'b0;
    reg        in_buf_full_flag = 1'b0, srqe = 1'b0, erre = 1'b0;
    reg  [7:0] md = 8'h00, ad = 8'h00;
    wire [7:0] bus, st, mk, ef, em, tmo, ec;
    wire [4:0] irq;
    wire [1:0] gt;
    wire       cen, cacs, busy;
    integer    failures = 0, comparisons = 0, n;
    grs_ctrl i_grs_ctrl (.core_clk_i(clk), .reset_i(rst), .soft_reset_i(srst),
        .is_sys_ctrl_i(sysc), .ifc_received_i(ifc), .out_buf_full_flag_i(out_buf_full_flag),
        .in_buf_full_flag_i(in_buf_full_flag), .task_done_set_i(td), .srq_event_i(srqe),
        .err_event_i(erre), .count_event_i(ev), .count_enable_set_i(ce),
        .mask_wr_i(mwr), .mask_data_i(md), .ack_wr_i(awr), .ack_data_i(ad),
        .int_status_o(st), .int_mask_o(mk), .err_flag_o(ef), .err_mask_o(em),
        .timeout_o(tmo), .event_count_o(ec), .count_enabled_o(cen), .srq_n_o(bus[7]),
        .attention_out_n_o(bus[6]), .ifc_n_o(bus[5]), .ren_n_o(bus[4]), .eoi_n_o(bus[3]),
        .dav_n_o(bus[2]), .in_charge_out_n_o(bus[1]), .system_ctrl_out_n_o(bus[0]),
        .task_done_irq_o(irq[4]), .special_irq_o(irq[3]), .out_buf_full_irq_o(irq[2]),
        .in_buf_not_full_irq_o(irq[1]), .clear_latch_out_o(irq[0]), .in_cacs_o(cacs),
        .busy_o(busy));
    grs_gate_model i_grs_gate_model (.ifc_received_i(ifc), .in_charge_out_n_i(bus[1]),
        .attention_out_n_i(bus[6]), .bus_in_charge_n_o(gt[1]), .bus_attention_n_o(gt[0]));
    // Clock and watchdog
    initial begin
        forever #10 clk = ~clk;
    end
    initial begin
        #400000 failures = failures + 1;
        test_done;
    end
    task step(input integer k); begin repeat (k) @(posedge clk); #1; end endtask
    task chk(input string nm, input [15:0] exp, input [15:0] got); begin
        comparisons = comparisons + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("[FAIL] %s exp %h got %h", nm, exp, got);
        end
    end endtask
    task test_done; begin
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    end endtask
    // Main sequence
    initial begin
        step(20); rst = 1'b0; step(5);
        chk("bus", 16'h00FF, bus);
        chk("irq", 16'h0000, irq);
        chk("regs", 16'h0000, st | mk | ef | em | tmo | ec);
        chk("state", 16'h0000, {busy, cacs, cen});
        mwr = 1'b1; md = 8'h01; step(1); mwr = 1'b0; td = 1'b1; step(1); td = 1'b0;
        chk("task", 16'h0011, {irq[4], 3'h0, st[2]});
        awr = 1'b1; ad = 8'h04; step(1); awr = 1'b0; mwr = 1'b1; md = 8'h00; step(1);
        chk("ack", 16'h0000, {irq[4], st[2]});
        mwr = 1'b0; td = 1'b1; out_buf_full_flag = 1'b1; step(1); td = 1'b0; step(1);
        chk("poll", 16'h0005, {irq[4], irq[2], st[2:0]});
        mwr = 1'b1; md = 8'h0E; step(1); mwr = 1'b0; srqe = 1'b1; erre = 1'b1; step(1);
        srqe = 1'b0; erre = 1'b0;
        chk("irqs", 16'h0007, irq[4:1]);
        chk("status", 16'h0065, st);
        awr = 1'b1; ad = 8'h60; srqe = 1'b1; in_buf_full_flag = 1'b1; step(1); awr = 1'b0; srqe = 1'b0;
        chk("ack set", 16'h0647, {irq[4:1], st});
        awr = 1'b1; ad = 8'h40; step(1); awr = 1'b0;
        chk("spec off", 16'h0207, {irq[4:1], st});
        ce = 1'b1; step(1); ce = 1'b0; ev = 1'b1; step(1);
        chk("count", 16'h01FF, {cen, ec});
        step(254);
        chk("near end", 16'h0001, {st[4], ec});
        step(1); ev = 1'b0;
        chk("wrap", 16'h0100, {st[4], ec});
        ifc = 1'b1; step(1);
        chk("clear", 16'h001F, {bus[6], bus[3], !cacs, gt});
        chk("latch", 16'h0003, {irq[0], st[3]});
        ifc = 1'b0; sysc = 1'b1; srst = 1'b1; step(1); srst = 1'b0; n = 0;
        while (bus[5] !== 1'b0 && n < 10) begin step(1); n = n + 1; end
        n = 0;
        while (bus[5] === 1'b0 && n < 6000) begin step(1); n = n + 1; end
        chk("pulse", 16'h1388, n[15:0]);
        chk("charge", 16'h0008, {bus[6], bus[1], cacs, busy, gt});
        chk("soft regs", 16'h0000, {irq, st | mk | ec});
        sysc = 1'b0; ifc = 1'b1; #1;
        chk("gate", 16'h0003, {bus[6], bus[1], gt});
        step(1);
        chk("drop", 16'h001D, {bus[6], bus[3], bus[1], cacs, irq[0]});
        step(1);
        test_done;
    end
endmodule // grs_ctrl_tb
